// File: hdl/nsmp_pkg.sv
/*
 * Constants and types shared by the NAND static memory port.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package nsmp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int NUM_CS   = 4;    // Chip selects served
   localparam int CS_IDX_W = 2;    // Width of a chip-select index
   localparam int TIME_W   = 6;    // Width of one timing count
   localparam int DATA_W   = 16;   // Widest flash data bus
   localparam int BYTE_W   = 8;    // Narrow flash data bus
   localparam int ADDR_W   = 32;   // Host address width

   ////////////////////////////////////////////////////////////////////////////
   // Address map: windows at 0x6000_0000 + cs * 0x0100_0000
   localparam logic [5:0] WIN_TAG      = 6'h18;  // Address bits 31..26
   localparam int         WIN_TAG_LSB  = 26;
   localparam int         WIN_SEL_LSB  = 24;     // Bits 25..24 pick the chip select
   localparam int         CMD_BIT      = 22;     // Command-latch select bit
   localparam int         ALE_BIT      = 21;     // Address-latch select bit

   ////////////////////////////////////////////////////////////////////////////
   // Field encodings
   localparam logic MODE_CS     = 1'b0;  // Chip select controls the access
   localparam logic MODE_STROBE = 1'b1;  // Read or write strobe controls it
   localparam logic WIDTH_8     = 1'b0;  // Bus width select: 8-bit flash
   localparam logic WIDTH_16    = 1'b1;  // Bus width select: 16-bit flash

   ////////////////////////////////////////////////////////////////////////////
   // Clock
   localparam int CLK_PERIOD_NS = 10;

   // Access sequencer states
   typedef enum logic [0:0] {
      NSMP_IDLE,
      NSMP_RUN
   } nsmp_state_t;

endpackage : nsmp_pkg

// File: hdl/nsmp_decode.sv
/*
 * Window decoder: maps a host address onto a chip select and a latch kind.
 * Assumes the caller checks hit before using the index.
 */
`timescale 1ns/1ps
`default_nettype none

module nsmp_decode
(
   // Host address
   input  wire logic [nsmp_pkg::ADDR_W-1:0]   addr,
   // Per chip select NAND mode
   input  wire logic [nsmp_pkg::NUM_CS-1:0]   nand_assign,
   // Decode result
   output logic                               hit,
   output logic [nsmp_pkg::CS_IDX_W-1:0]      cs_idx,
   output logic                               is_cmd,
   output logic                               is_adr
);

   logic [nsmp_pkg::CS_IDX_W-1:0] idx;
   logic                          nand_on;

   // Window match and latch-strobe decoding; command wins if both bits set
   always_comb
   begin
      idx     = addr[nsmp_pkg::WIN_SEL_LSB +: nsmp_pkg::CS_IDX_W];
      hit     = (addr[nsmp_pkg::ADDR_W-1:nsmp_pkg::WIN_TAG_LSB] == nsmp_pkg::WIN_TAG)
                && (int'(idx) < nsmp_pkg::NUM_CS);
      nand_on = hit && nand_assign[idx];
      cs_idx  = idx;
      is_cmd  = nand_on && addr[nsmp_pkg::CMD_BIT];
      is_adr  = nand_on && addr[nsmp_pkg::ALE_BIT] && !addr[nsmp_pkg::CMD_BIT];
   end

endmodule : nsmp_decode

`default_nettype wire

// File: hdl/nsmp_phase.sv
/*
 * Phase window of one strobe: setup, pulse and hold counted in core cycles.
 * Assumes cnt starts at zero with the access and pulse is never zero.
 */
`timescale 1ns/1ps
`default_nettype none

module nsmp_phase
#(
   parameter int TW = nsmp_pkg::TIME_W
)
(
   // Position within the access
   input  wire logic [TW+1:0] cnt,
   // Programmed phases
   input  wire logic [TW-1:0] setup,
   input  wire logic [TW-1:0] pulse,
   input  wire logic [TW-1:0] hold,
   // Strobe window and length
   output logic               active,
   output logic               pulse_last,
   output logic [TW+1:0]      total
);

   logic [TW+1:0] pulse_end;

   // Strobe is active from setup up to the end of the pulse
   always_comb
   begin
      pulse_end  = {2'b00, setup} + {2'b00, pulse};
      total      = pulse_end + {2'b00, hold};
      active     = (cnt >= {2'b00, setup}) && (cnt < pulse_end);
      pulse_last = (cnt == pulse_end - 1'b1);
   end

endmodule : nsmp_phase

`default_nettype wire

// File: hdl/nsmp_port.sv
/*
 * NAND support of a static memory port: host accesses in four chip-select
 * windows become command, address and data cycles on the flash pins.
 * Assumes one host request at a time, inputs synchronous to clk, and
 * core_clk_en high whenever the power manager lets the core clock run.
 */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module nsmp_port
#(
   parameter int NUM_CS = nsmp_pkg::NUM_CS,
   parameter int TW     = nsmp_pkg::TIME_W
)
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     srst,
   input  wire logic                     core_clk_en,

   // Host request
   input  wire logic                     req_valid,
   output logic                          req_ready,
   input  wire logic                     req_write,
   input  wire logic [nsmp_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [nsmp_pkg::DATA_W-1:0] req_wdata,

   // Host answer
   output logic                          rsp_valid,
   output logic                          rsp_err,
   output logic [nsmp_pkg::DATA_W-1:0]   rsp_rdata,

   // Configuration per chip select
   input  wire logic [NUM_CS-1:0]        nand_cs_assign,
   input  wire logic [NUM_CS-1:0]        bus_width_select,
   input  wire logic [NUM_CS-1:0]        read_mode,
   input  wire logic [NUM_CS-1:0]        write_mode,

   // Read timing per chip select, packed cs0 in the low field
   input  wire logic [NUM_CS*TW-1:0]     rd_strobe_setup,
   input  wire logic [NUM_CS*TW-1:0]     rd_strobe_pulse,
   input  wire logic [NUM_CS*TW-1:0]     rd_strobe_hold,
   input  wire logic [NUM_CS*TW-1:0]     cs_rd_setup,
   input  wire logic [NUM_CS*TW-1:0]     cs_rd_pulse,
   input  wire logic [NUM_CS*TW-1:0]     cs_rd_hold,

   // Write timing per chip select
   input  wire logic [NUM_CS*TW-1:0]     wr_strobe_setup,
   input  wire logic [NUM_CS*TW-1:0]     wr_strobe_pulse,
   input  wire logic [NUM_CS*TW-1:0]     wr_strobe_hold,
   input  wire logic [NUM_CS*TW-1:0]     cs_wr_setup,
   input  wire logic [NUM_CS*TW-1:0]     cs_wr_pulse,
   input  wire logic [NUM_CS*TW-1:0]     cs_wr_hold,

   // Resulting cycle lengths per chip select
   output logic [NUM_CS*(TW+2)-1:0]      rd_total_cycle,
   output logic [NUM_CS*(TW+2)-1:0]      wr_total_cycle,

   // Status
   output logic                          busy,

   // Flash pins
   output logic [NUM_CS-1:0]             nand_chip_select_n,
   output logic                          flash_output_enable_n,
   output logic                          flash_write_strobe_n,
   output logic                          cmd_latch,
   output logic                          addr_latch,
   output logic [nsmp_pkg::DATA_W-1:0]   flash_data_o,
   output logic                          flash_data_oe,
   input  wire logic [nsmp_pkg::DATA_W-1:0] flash_data_i
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   // Window decoding has room for four chip selects only
   if (NUM_CS < 1 || NUM_CS > nsmp_pkg::NUM_CS)
   begin : g_bad_cs
      $error("NUM_CS must lie between 1 and 4");
   end
   if (TW < 2 || TW > 8)
   begin : g_bad_tw
      $error("TW must lie between 2 and 8");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Types and helpers

   localparam int DW = nsmp_pkg::DATA_W;
   localparam int BW = nsmp_pkg::BYTE_W;
   localparam int CW = TW + 2;

   // Whole state of the port
   typedef struct packed {
      nsmp_pkg::nsmp_state_t           st;
      logic [nsmp_pkg::CS_IDX_W-1:0]   cs;
      logic                            wr;
      logic                            cmd;
      logic                            adr;
      logic                            wide;
      logic                            mode;
      logic [CW-1:0]                   cnt;
      logic [TW-1:0]                   s_set;
      logic [TW-1:0]                   s_pul;
      logic [TW-1:0]                   s_hld;
      logic [TW-1:0]                   c_set;
      logic [TW-1:0]                   c_pul;
      logic [TW-1:0]                   c_hld;
      logic [DW-1:0]                   wdata;
      logic [DW-1:0]                   rdata;
      logic                            rsp_valid;
      logic                            rsp_err;
   } nsmp_regs_t;

   // Field of one chip select, zero for an index outside the port
   function automatic logic [TW-1:0] nsmp_field
   (
      input logic [NUM_CS*TW-1:0]         v,
      input logic [nsmp_pkg::CS_IDX_W-1:0] i
   );
      logic [TW-1:0] f;
      f = '0;
      if (int'(i) < NUM_CS)
      begin
         f = v[int'(i)*TW +: TW];
      end
      return f;
   endfunction : nsmp_field

   // Field of the read or the write set, by direction
   function automatic logic [TW-1:0] nsmp_dir
   (
      input logic                          wr,
      input logic [NUM_CS*TW-1:0]          rd_v,
      input logic [NUM_CS*TW-1:0]          wr_v,
      input logic [nsmp_pkg::CS_IDX_W-1:0] i
   );
      return wr ? nsmp_field(wr_v, i) : nsmp_field(rd_v, i);
   endfunction : nsmp_dir

   // Narrow flash keeps only the low byte lane
   function automatic logic [DW-1:0] nsmp_lane
   (
      input logic          wide,
      input logic [DW-1:0] d
   );
      return wide ? d : {{(DW-BW){1'b0}}, d[BW-1:0]};
   endfunction : nsmp_lane

   ////////////////////////////////////////////////////////////////////////////
   // Signals

   nsmp_regs_t                    r_q;
   nsmp_regs_t                    r_d;
   logic                          dec_hit;
   logic [nsmp_pkg::CS_IDX_W-1:0] dec_cs;
   logic                          dec_cmd;
   logic                          dec_adr;
   logic                          s_active;
   logic                          s_last;
   logic [CW-1:0]                 s_total;
   logic                          c_active;
   logic                          c_last;
   logic [CW-1:0]                 c_total;
   logic                          run;
   logic                          ctl_last;
   logic [CW-1:0]                 end_cnt;
   logic                          zero_pulse;

   ////////////////////////////////////////////////////////////////////////////
   // Address decoding and phase windows

   nsmp_decode u_decode
   (
      .addr        (req_addr),
      .nand_assign (nand_cs_assign),
      .hit         (dec_hit),
      .cs_idx      (dec_cs),
      .is_cmd      (dec_cmd),
      .is_adr      (dec_adr)
   );

   // Read or write strobe window
   nsmp_phase #(.TW(TW)) u_strobe
   (
      .cnt        (r_q.cnt),
      .setup      (r_q.s_set),
      .pulse      (r_q.s_pul),
      .hold       (r_q.s_hld),
      .active     (s_active),
      .pulse_last (s_last),
      .total      (s_total)
   );

   // Chip-select window
   nsmp_phase #(.TW(TW)) u_select
   (
      .cnt        (r_q.cnt),
      .setup      (r_q.c_set),
      .pulse      (r_q.c_pul),
      .hold       (r_q.c_hld),
      .active     (c_active),
      .pulse_last (c_last),
      .total      (c_total)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Cycle lengths shown per chip select

   // Each length follows the signal that controls that direction
   for (genvar g = 0; g < NUM_CS; g++)
   begin : g_total
      logic [CW-1:0] rs;
      logic [CW-1:0] rc;
      logic [CW-1:0] ws;
      logic [CW-1:0] wc;
      assign rs = CW'(rd_strobe_setup[g*TW +: TW]) + CW'(rd_strobe_pulse[g*TW +: TW])
                  + CW'(rd_strobe_hold[g*TW +: TW]);
      assign rc = CW'(cs_rd_setup[g*TW +: TW]) + CW'(cs_rd_pulse[g*TW +: TW])
                  + CW'(cs_rd_hold[g*TW +: TW]);
      assign ws = CW'(wr_strobe_setup[g*TW +: TW]) + CW'(wr_strobe_pulse[g*TW +: TW])
                  + CW'(wr_strobe_hold[g*TW +: TW]);
      assign wc = CW'(cs_wr_setup[g*TW +: TW]) + CW'(cs_wr_pulse[g*TW +: TW])
                  + CW'(cs_wr_hold[g*TW +: TW]);
      assign rd_total_cycle[g*CW +: CW] = (read_mode[g] == nsmp_pkg::MODE_STROBE) ? rs : rc;
      assign wr_total_cycle[g*CW +: CW] = (write_mode[g] == nsmp_pkg::MODE_STROBE) ? ws : wc;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Controlling signal of the running access

   // Mode picks whose timing closes the access and samples the data
   always_comb
   begin
      run        = (r_q.st == nsmp_pkg::NSMP_RUN);
      ctl_last   = (r_q.mode == nsmp_pkg::MODE_STROBE) ? s_last : c_last;
      end_cnt    = ((r_q.mode == nsmp_pkg::MODE_STROBE) ? s_total : c_total) - 1'b1;
      zero_pulse = (nsmp_dir(req_write, rd_strobe_pulse, wr_strobe_pulse, dec_cs) == '0)
                   || (nsmp_dir(req_write, cs_rd_pulse, cs_wr_pulse, dec_cs) == '0);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer next state

   always_comb
   begin
      r_d           = r_q;
      r_d.rsp_valid = 1'b0;
      r_d.rsp_err   = 1'b0;
      case (r_q.st)
         nsmp_pkg::NSMP_IDLE:
         begin
            if (req_valid)
            begin
               // Capture direction, window and this chip select's timing
               r_d.wr    = req_write;
               r_d.cs    = dec_cs;
               r_d.cmd   = req_write && dec_cmd;
               r_d.adr   = req_write && dec_adr;
               r_d.wide  = (int'(dec_cs) < NUM_CS) && bus_width_select[dec_cs];
               r_d.mode  = (int'(dec_cs) < NUM_CS) &&
                           (req_write ? write_mode[dec_cs] : read_mode[dec_cs]);
               r_d.s_set = nsmp_dir(req_write, rd_strobe_setup, wr_strobe_setup, dec_cs);
               r_d.s_pul = nsmp_dir(req_write, rd_strobe_pulse, wr_strobe_pulse, dec_cs);
               r_d.s_hld = nsmp_dir(req_write, rd_strobe_hold, wr_strobe_hold, dec_cs);
               r_d.c_set = nsmp_dir(req_write, cs_rd_setup, cs_wr_setup, dec_cs);
               r_d.c_pul = nsmp_dir(req_write, cs_rd_pulse, cs_wr_pulse, dec_cs);
               r_d.c_hld = nsmp_dir(req_write, cs_rd_hold, cs_wr_hold, dec_cs);
               r_d.cnt   = '0;
               r_d.wdata = req_wdata;
               if (!dec_hit || zero_pulse)
               begin
                  // Outside every window or illegal timing: refuse at once
                  r_d.rsp_valid = 1'b1;
                  r_d.rsp_err   = 1'b1;
               end
               else
               begin
                  r_d.st = nsmp_pkg::NSMP_RUN;
               end
            end
         end
         nsmp_pkg::NSMP_RUN:
         begin
            // Counters move only while the core clock is enabled
            if (core_clk_en)
            begin
               if (ctl_last && !r_q.wr)
               begin
                  r_d.rdata = nsmp_lane(r_q.wide, flash_data_i);
               end
               if (r_q.cnt == end_cnt)
               begin
                  r_d.st        = nsmp_pkg::NSMP_IDLE;
                  r_d.rsp_valid = 1'b1;
               end
               else
               begin
                  r_d.cnt = r_q.cnt + 1'b1;
               end
            end
         end
         default:
         begin
            r_d.st = nsmp_pkg::NSMP_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         r_q    <= '0;
         r_q.st <= nsmp_pkg::NSMP_IDLE;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Host side outputs

   assign req_ready = !run;
   assign busy      = run;
   assign rsp_valid = r_q.rsp_valid;
   assign rsp_err   = r_q.rsp_err;
   assign rsp_rdata = r_q.rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Flash pins

   // Only the addressed chip select pulses, inside its own window
   for (genvar g = 0; g < NUM_CS; g++)
   begin : g_cs
      assign nand_chip_select_n[g] = !(run && (int'(r_q.cs) == g) && c_active);
   end

   // Strobes and latches follow the strobe window of their direction
   assign flash_output_enable_n = !(run && !r_q.wr && s_active);
   assign flash_write_strobe_n  = !(run && r_q.wr && s_active);
   assign cmd_latch             = run && r_q.wr && r_q.cmd && s_active;
   assign addr_latch            = run && r_q.wr && r_q.adr && s_active;

   // Write data is driven for the whole access, through the hold cycles after the strobe's rise when the strobe controls the write
   assign flash_data_oe = run && r_q.wr;
   assign flash_data_o  = nsmp_lane(r_q.wide, r_q.wdata);

endmodule : nsmp_port

`default_nettype wire

// File: tb/nsmp_monitor.sv
/* Pin and answer checks of the NAND port.
   Bound to nsmp_port; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module nsmp_monitor
#(
   parameter int NUM_CS = 4,
   parameter int TW     = 6
)
(
   // Clock, reset and host side
   input wire logic                          clk,
   input wire logic                          srst,
   input wire logic                          req_valid,
   input wire logic                          req_ready,
   input wire logic [nsmp_pkg::ADDR_W-1:0]   req_addr,
   input wire logic                          rsp_valid,
   input wire logic                          rsp_err,
   input wire logic                          busy,
   // Flash pins
   input wire logic [NUM_CS-1:0]             nand_chip_select_n,
   input wire logic                          flash_output_enable_n,
   input wire logic                          flash_write_strobe_n,
   input wire logic                          cmd_latch,
   input wire logic                          addr_latch,
   input wire logic [nsmp_pkg::DATA_W-1:0]   flash_data_o,
   input wire logic                          flash_data_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_latch_exclusive: assert property (!(cmd_latch && addr_latch))
      else $error("both latch strobes high");
   a_latch_in_pulse: assert property ((cmd_latch || addr_latch) |-> !flash_write_strobe_n && flash_data_oe)
      else $error("latch strobe outside write pulse");
   a_single_select: assert property ($onehot0(~nand_chip_select_n))
      else $error("more than one chip select low");
   a_idle_quiet: assert property (!busy |-> &nand_chip_select_n && flash_write_strobe_n && flash_output_enable_n)
      else $error("pin activity while idle");
   a_bad_window: assert property (req_valid && req_ready && req_addr[31:26] != 6'h18 |=> rsp_valid && rsp_err)
      else $error("outside window not refused");
   a_data_held: assert property (!flash_write_strobe_n && $past(!flash_write_strobe_n) |-> $stable(flash_data_o))
      else $error("write data moved in pulse");
   a_write_driven: assert property (!flash_write_strobe_n |-> flash_data_oe && flash_output_enable_n)
      else $error("write strobe without driven data");
   a_read_undriven: assert property (!flash_output_enable_n |-> !flash_data_oe)
      else $error("bus driven during read");
   a_end_answer: assert property ($fell(busy) |-> rsp_valid && !rsp_err)
      else $error("access ended without answer");
   // Main scenarios
   c_cmd: cover property (cmd_latch);
   c_adr: cover property (addr_latch);
   c_err: cover property (rsp_valid && rsp_err);
endmodule : nsmp_monitor
bind nsmp_port nsmp_monitor #(.NUM_CS(NUM_CS), .TW(TW)) mon_u (.clk(clk), .srst(srst), .req_valid(req_valid),
   .req_ready(req_ready), .req_addr(req_addr), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .busy(busy),
   .nand_chip_select_n(nand_chip_select_n), .flash_output_enable_n(flash_output_enable_n),
   .flash_write_strobe_n(flash_write_strobe_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
   .flash_data_o(flash_data_o), .flash_data_oe(flash_data_oe));
`default_nettype wire

// File: tb/nsmp_flash_model.sv
/* Behavioural NAND flash shared by all chip selects.
   Assumes synchronous pins; ready/busy is not modelled, the bench waits for each answer. */
`timescale 1ns/1ps
`default_nettype none
module nsmp_flash_model
(
   // Pins from the port
   input wire logic                          clk,
   input wire logic [nsmp_pkg::NUM_CS-1:0]   nand_chip_select_n,
   input wire logic                          flash_output_enable_n,
   input wire logic                          flash_write_strobe_n,
   input wire logic                          cmd_latch,
   input wire logic                          addr_latch,
   input wire logic [nsmp_pkg::DATA_W-1:0]   flash_data_o,
   // Read bus and captured values
   output logic [nsmp_pkg::DATA_W-1:0]       flash_data_i,
   output logic [7:0]                        cmd_seen,
   output logic [7:0]                        adr_seen,
   output logic [nsmp_pkg::DATA_W-1:0]       mem,
   output logic [nsmp_pkg::NUM_CS-1:0]       cs_seen
);
   logic                        sel;
   logic [nsmp_pkg::DATA_W-1:0] alt_q = 16'h5A5A;
   // No ready/busy pin: the bench starts an access only after the last answer
   // Enable taken from the chip select only
   assign sel = ~&nand_chip_select_n;
   // Stored word while read enabled, else a pattern moving each cycle
   assign flash_data_i = (sel && !flash_output_enable_n) ? mem : alt_q;
   // Bus taken while write strobe low; last low cycle is the rising-edge value
   always @(posedge clk)
   begin
      alt_q <= ~alt_q;
      if (sel && !flash_write_strobe_n)
      begin
         cs_seen <= ~nand_chip_select_n;
         if (cmd_latch) cmd_seen <= flash_data_o[7:0];
         else if (addr_latch) adr_seen <= flash_data_o[7:0];
         else mem <= flash_data_o;
      end
   end
endmodule : nsmp_flash_model
`default_nettype wire

// File: tb/nsmp_port_tb.sv
/* Self-checking bench of nsmp_port with random timing and modes.
   Assumes the flash model on the pins and the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
module nsmp_port_tb;
   localparam int PW = nsmp_pkg::NUM_CS * nsmp_pkg::TIME_W;
   logic clk, srst, core_clk_en, req_valid, req_ready, req_write, rsp_valid, rsp_err;
   logic oe_n, we_n, cle, ale;
   logic [31:0] req_addr, seed;
   logic [15:0] req_wdata, rsp_rdata, fdo, fdi, mem;
   logic [7:0] cmd_seen, adr_seen;
   logic [3:0] wm, rm, bw, na, cs_n, cs_seen;
   logic [PW-1:0] p_ss, p_sp, p_sh, p_ch;
   logic [31:0] rdt, wrt;
   int errors = 0;
   int checks_done = 0;
   int it;
   always #(nsmp_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
   nsmp_port dut_u (.clk(clk), .srst(srst), .core_clk_en(core_clk_en), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .nand_cs_assign(na),
      .bus_width_select(bw), .read_mode(rm), .write_mode(wm), .rd_strobe_setup(p_ss), .rd_strobe_pulse(p_sp),
      .rd_strobe_hold(p_sh), .cs_rd_setup(p_ss), .cs_rd_pulse(p_sp), .cs_rd_hold(p_ch), .wr_strobe_setup(p_ss),
      .wr_strobe_pulse(p_sp), .wr_strobe_hold(p_sh), .cs_wr_setup(p_ss), .cs_wr_pulse(p_sp), .cs_wr_hold(p_ch),
      .rd_total_cycle(rdt), .wr_total_cycle(wrt), .busy(), .nand_chip_select_n(cs_n),
      .flash_output_enable_n(oe_n), .flash_write_strobe_n(we_n), .cmd_latch(cle), .addr_latch(ale),
      .flash_data_o(fdo), .flash_data_oe(), .flash_data_i(fdi));
   nsmp_flash_model flash_u (.clk(clk), .nand_chip_select_n(cs_n), .flash_output_enable_n(oe_n),
      .flash_write_strobe_n(we_n), .cmd_latch(cle), .addr_latch(ale), .flash_data_o(fdo), .flash_data_i(fdi),
      .cmd_seen(cmd_seen), .adr_seen(adr_seen), .mem(mem), .cs_seen(cs_seen));
   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Cycle length of the controlling signal
   function automatic logic [15:0] tot(input int i, input logic m);
      return 16'(p_ss[6*i+:6]) + 16'(p_sp[6*i+:6]) + 16'(m ? p_sh[6*i+:6] : p_ch[6*i+:6]);
   endfunction : tot
   task automatic end_sim();
      if (errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One request; n counts enabled edges until the answer
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [15:0] d, output logic [15:0] n);
      int k;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      // A refused request answers right after the take edge
      #1;
      for (k = 0; k < 300 && rsp_valid !== 1'b1; k++)
      begin
         @(posedge clk);
         n += 16'(core_clk_en);
         core_clk_en <= (rnd() % 4) != 0;
         #1;
      end
      core_clk_en = 1'b1;
      if (rsp_valid !== 1'b1)
      begin
         errors++;
         end_sim();
      end
   endtask : xfer
   // Random timing per chip select; pulses never zero
   task automatic cfg();
      @(posedge clk);
      for (int i = 0; i < 4; i++)
      begin
         p_ss[6*i+:6] <= 6'(rnd() % 3);
         p_sp[6*i+:6] <= 6'(1 + rnd() % 3);
         p_sh[6*i+:6] <= 6'(rnd() % 3);
         p_ch[6*i+:6] <= 6'(rnd() % 3);
      end
      {wm, rm, bw, na} <= 16'(rnd());
      // Let the new settings land before expectations are formed
      #1;
   endtask : cfg
   // kind 0 data, 1 command, 2 address; data is read back
   task automatic op(input int i, input int kind, input logic [15:0] d0);
      logic [15:0] d, n;
      logic [31:0] a;
      d = bw[i] ? d0 : {8'h00, d0[7:0]};
      a = 32'h6000_0000 + 32'(i) * 32'h0100_0000 + (kind == 1 ? 32'h0040_0000 : kind == 2 ? 32'h0020_0000 : 0);
      chk("read total", tot(i, rm[i]), 16'(rdt[8*i+:8]));
      chk("write total", tot(i, wm[i]), 16'(wrt[8*i+:8]));
      xfer(1'b1, a, d, n);
      chk("write length", tot(i, wm[i]), n);
      chk("write error", 16'h0000, 16'(rsp_err));
      chk("selected", 16'(1 << i), 16'(cs_seen));
      if (kind == 1 && na[i]) chk("command byte", {8'h00, d[7:0]}, {8'h00, cmd_seen});
      else if (kind == 2 && na[i]) chk("address byte", {8'h00, d[7:0]}, {8'h00, adr_seen});
      else
      begin
         chk("data word", d, mem);
         xfer(1'b0, a, 16'h0000, n);
         chk("read length", tot(i, rm[i]), n);
         chk("read word", d, rsp_rdata);
      end
   endtask : op
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      logic [15:0] n, m0;
      clk = 0;
      srst = 1;
      seed = 32'h3858;
      core_clk_en = 1;
      req_valid = 0;
      req_write = 0;
      req_addr = 0;
      req_wdata = 0;
      {p_ss, p_sh, p_ch} = '0;
      p_sp = {4{6'h01}};
      {wm, rm, bw} = '0;
      na = 4'hF;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      op(0, 1, 16'h0090);
      op(0, 2, 16'h0000);
      op(3, 0, 16'hA5C3);
      for (it = 0; it < 80; it++)
      begin
         cfg();
         op(int'(rnd() % 4), int'(rnd() % 3), 16'(rnd()));
      end
      m0 = mem;
      xfer(1'b1, 32'h6400_0000, 16'h0011, n);
      chk("outside window", 16'h0001, 16'(rsp_err));
      xfer(1'b0, 32'h5F00_0000, 16'h0000, n);
      chk("below window", 16'h0001, 16'(rsp_err));
      @(posedge clk);
      p_sp[5:0] <= 6'h00;
      xfer(1'b1, 32'h6000_0000, 16'h0022, n);
      chk("zero pulse", 16'h0001, 16'(rsp_err));
      chk("refused write", m0, mem);
      end_sim();
   end
endmodule : nsmp_port_tb
`default_nettype wire
